// >>> test/board_reset_sequencer_bench.sv
// Self-checking bench for the board reset sequencer
`timescale 1ns/1ps
module board_reset_sequencer_bench;
  localparam int POR = 50;
  localparam int MCLK = 20;
  localparam int MPWR = 40;
  logic       ref_clk_i, rst_i, core_supply_good_i, mgmt_clock_good_i;
  logic       system_poweron_clear_n_o, system_clear_n_o, chip_clear_n_o;
  logic       soft_clear_n_o, mgmt_ctrl_clear_n_o, seq_done_o;
  logic [3:0] mgmt_supply_good_i, rail_en;
  logic [2:0] en;
  logic [7:0] ramp, v, pv;
  int         t [8];
  int         cyc = 0;
  int         err_total = 0;
  int         num_checks = 0;
  int         i, k, n;
  supply_model model (.ref_clk_i(ref_clk_i), .en_i(en), .rail_en_i(rail_en),
    .ramp_i(ramp), .core_good_o(core_supply_good_i),
    .rail_good_o(mgmt_supply_good_i), .clk_good_o(mgmt_clock_good_i));
  board_reset_sequencer #(.POR_CYC(POR), .MCLK_CYC(MCLK), .MPWR_CYC(MPWR))
    dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .core_supply_good_i(core_supply_good_i),
    .mgmt_supply_good_i(mgmt_supply_good_i),
    .mgmt_clock_good_i(mgmt_clock_good_i),
    .system_poweron_clear_n_o(system_poweron_clear_n_o),
    .system_clear_n_o(system_clear_n_o), .chip_clear_n_o(chip_clear_n_o),
    .soft_clear_n_o(soft_clear_n_o),
    .mgmt_ctrl_clear_n_o(mgmt_ctrl_clear_n_o), .seq_done_o(seq_done_o));
  assign v = {mgmt_ctrl_clear_n_o, chip_clear_n_o, soft_clear_n_o,
    system_clear_n_o, system_poweron_clear_n_o, &mgmt_supply_good_i,
    mgmt_clock_good_i, core_supply_good_i};
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input logic ok);
    num_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t clear timing or level wrong", $time);
    end
  endtask : chk
  // Power-on clear survives only a loss of the reference clock
  function automatic logic exp_por_after_drop(input int kind);
    return (kind == 2) ? 1'b1 : 1'b0;
  endfunction : exp_por_after_drop
  task automatic summarize();
    if (err_total == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  // Rise times of causes and clears, plus the hang limit
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    pv <= v;
    for (int j = 0; j < 8; j++)
      if (v[j] && !pv[j])
        t[j] <= cyc;
    if (cyc > 5000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'hA761));
    rst_i = 1'b1;
    en = 3'h0;
    rail_en = 4'h0;
    ramp = 8'h00;
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 6; i++) begin
      @(posedge ref_clk_i);
      en <= 3'h0;
      repeat (10) @(posedge ref_clk_i);
      chk(v[7:3] === 5'h00);
      rail_en <= 4'hF;
      ramp <= (i == 0) ? 8'h00 : 8'($urandom % 20);
      for (k = 0; k < 3; k++) begin
        repeat ($urandom % 30 + 1) @(posedge ref_clk_i);
        en[(i + k) % 3] <= 1'b1;
      end
      n = 0;
      while (!(seq_done_o === 1'b1 && v[7] === 1'b1) && n < 1000) begin
        @(posedge ref_clk_i);
        n++;
      end
      repeat (2) @(posedge ref_clk_i);
      chk(n < 1000);
      chk(t[3] - t[0] >= POR);
      chk(t[4] >= t[3]);
      chk(t[5] - t[3] >= 100);
      chk(t[6] - t[5] >= 100);
      chk(t[7] - t[1] >= MCLK);
      chk(t[7] - t[2] >= MPWR);
      k = i % 3;
      if (k == 1)
        rail_en[$urandom % 4] <= 1'b0;
      else
        en[k] <= 1'b0;
      repeat (10) @(posedge ref_clk_i);
      chk(v[7] === 1'b0);
      chk(v[3] === exp_por_after_drop(k));
    end
    summarize();
  end
endmodule : board_reset_sequencer_bench

// >>> test/seq_properties.sv
// Timing properties of the board reset sequencer
`timescale 1ns/1ps
module seq_props #(
  parameter int unsigned NUM_MGMT_SUPPLIES = 4,
  parameter int unsigned POR_CYC           = 20000,
  parameter int unsigned MCLK_CYC          = 10000,
  parameter int unsigned MPWR_CYC          = 20000
) (
  // Clock, reset and status
  input wire logic                         ref_clk_i,
  input wire logic                         rst_i,
  input wire logic                         core_supply_good_i,
  input wire logic [NUM_MGMT_SUPPLIES-1:0] mgmt_supply_good_i,
  input wire logic                         mgmt_clock_good_i,
  // Clears and status
  input wire logic                         system_poweron_clear_n_o,
  input wire logic                         system_clear_n_o,
  input wire logic                         chip_clear_n_o,
  input wire logic                         soft_clear_n_o,
  input wire logic                         mgmt_ctrl_clear_n_o,
  input wire logic                         seq_done_o
);
  int unsigned cg, kc, kp, pc;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Cycles each cause has been steady
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cg <= 0;
      kc <= 0;
      kp <= 0;
      pc <= 0;
    end else begin
      cg <= core_supply_good_i ? cg + 1 : 0;
      kc <= mgmt_clock_good_i ? kc + 1 : 0;
      kp <= &mgmt_supply_good_i ? kp + 1 : 0;
      pc <= system_poweron_clear_n_o ? pc + 1 : 0;
    end
  end
  a_por_wait: assert property ($rose(system_poweron_clear_n_o) |-> cg >= POR_CYC)
    else $error("power-on clear released early");
  a_sys_order: assert property (system_clear_n_o |-> system_poweron_clear_n_o)
    else $error("system clear before power-on clear");
  a_soft_width: assert property ($rose(soft_clear_n_o) |-> pc >= reset_seq_pkg::PULSE_CYC)
    else $error("soft clear pulse too short");
  a_chip_gap: assert property ($rose(chip_clear_n_o) |-> $past(soft_clear_n_o, 100))
    else $error("chip clear gap too short");
  a_chip_order: assert property (chip_clear_n_o |-> soft_clear_n_o)
    else $error("chip clear before soft clear");
  a_mgmt_clock: assert property ($rose(mgmt_ctrl_clear_n_o) |-> kc >= MCLK_CYC)
    else $error("mgmt clear before clock stable");
  a_mgmt_power: assert property ($rose(mgmt_ctrl_clear_n_o) |-> kp >= MPWR_CYC)
    else $error("mgmt clear before supplies stable");
  a_drop_all: assert property ($fell(core_supply_good_i && &mgmt_supply_good_i) |-> ##[1:8] !(system_poweron_clear_n_o || system_clear_n_o || chip_clear_n_o || soft_clear_n_o || mgmt_ctrl_clear_n_o))
    else $error("clears not reasserted on supply drop");
  cover property ($rose(seq_done_o));
  cover property ($rose(mgmt_ctrl_clear_n_o));
  cover property ($fell(system_poweron_clear_n_o));
endmodule : seq_props
bind board_reset_sequencer seq_props #(.NUM_MGMT_SUPPLIES(NUM_MGMT_SUPPLIES),
  .POR_CYC(POR_CYC), .MCLK_CYC(MCLK_CYC), .MPWR_CYC(MPWR_CYC)) props (.*);

// >>> test/supply_model.sv
// Behavioural model of the board regulators and reference clock
`timescale 1ns/1ps
module supply_model (
  // Clock and enables
  input  wire logic       ref_clk_i,
  input  wire logic [2:0] en_i,
  input  wire logic [3:0] rail_en_i,
  input  wire logic [7:0] ramp_i,
  // Good indications
  output logic            core_good_o,
  output logic [3:0]      rail_good_o,
  output logic            clk_good_o
);
  logic [7:0] cnt [3];
  logic [2:0] on;
  assign on = en_i & {1'b1, &rail_en_i, 1'b1};
  // Good only once the ramp time has passed
  always_ff @(posedge ref_clk_i) begin
    for (int k = 0; k < 3; k++) begin
      if (!on[k])
        cnt[k] <= 8'h00;
      else if (cnt[k] != 8'hFF)
        cnt[k] <= cnt[k] + 8'h01;
    end
  end
  assign core_good_o = on[0] && cnt[0] >= ramp_i;
  assign rail_good_o = rail_en_i & {4{on[1] && cnt[1] >= ramp_i}};
  assign clk_good_o  = on[2] && cnt[2] >= ramp_i;
endmodule : supply_model

// >>> verilog/board_reset_sequencer.sv
// Board reset sequencer for controller chips and management controller
`timescale 1ns/1ps
module board_reset_sequencer #(
  parameter int unsigned NUM_MGMT_SUPPLIES = 4,
  parameter int unsigned POR_CYC  = reset_seq_pkg::POR_CYC,
  parameter int unsigned MCLK_CYC = reset_seq_pkg::MCLK_CYC,
  parameter int unsigned MPWR_CYC = reset_seq_pkg::MPWR_CYC
) (
  // Clock and reset
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_i,
  // Supply and clock status from the board
  input  wire logic                         core_supply_good_i,
  input  wire logic [NUM_MGMT_SUPPLIES-1:0] mgmt_supply_good_i,
  input  wire logic                         mgmt_clock_good_i,
  // Controller chip clears
  output logic                              system_poweron_clear_n_o,
  output logic                              system_clear_n_o,
  output logic                              chip_clear_n_o,
  output logic                              soft_clear_n_o,
  // Management controller clear
  output logic                              mgmt_ctrl_clear_n_o,
  // Sequence status
  output logic                              seq_done_o
);
  // ============================================================
  // Stage lengths in reference clock cycles
  localparam int unsigned CW = reset_seq_pkg::CNT_W;
  localparam logic [CW-1:0] PULSE_LAST =
    CW'(reset_seq_pkg::PULSE_CYC - 1);
  localparam logic [CW-1:0] GAP_LAST  =
    CW'(reset_seq_pkg::SOFT_GAP_CYC - 1);

  typedef struct packed {
    reset_seq_pkg::seq_state_e st;
    logic [CW-1:0]             cnt;
    logic                      por_n;
    logic                      sys_n;
    logic                      chip_n;
    logic                      soft_n;
    logic                      mgmt_n;
    logic                      done;
  } seq_s;

  // All clears asserted, sequence parked
  localparam seq_s SEQ_RESET = '{
    st:     reset_seq_pkg::ST_HOLD,
    cnt:    '0,
    por_n:  1'b0,
    sys_n:  1'b0,
    chip_n: 1'b0,
    soft_n: 1'b0,
    mgmt_n: 1'b0,
    done:   1'b0
  };

  seq_s r;
  seq_s next_r;
  logic core_good;
  logic core_stable;
  logic mclk_stable;
  logic mpwr_good;
  logic mpwr_stable;
  logic supply_drop;
  logic por_go;
  logic pulse_end;
  logic gap_end;
  logic mgmt_go;

  // ============================================================
  // Input filtering and stability timing
  // Core supply, timed for the power-on delay
  stable_timer #(
    .WIDTH   (1),
    .HOLD_CYC(POR_CYC),
    .CNT_W   (CW)
  ) u_core (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .level_i   (core_supply_good_i),
    .all_good_o(core_good),
    .stable_o  (core_stable)
  );

  // Management reference clock
  stable_timer #(
    .WIDTH   (1),
    .HOLD_CYC(MCLK_CYC),
    .CNT_W   (CW)
  ) u_mclk (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .level_i   (mgmt_clock_good_i),
    .all_good_o(),
    .stable_o  (mclk_stable)
  );

  // Management controller supplies
  stable_timer #(
    .WIDTH   (NUM_MGMT_SUPPLIES),
    .HOLD_CYC(MPWR_CYC),
    .CNT_W   (CW)
  ) u_mpwr (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .level_i   (mgmt_supply_good_i),
    .all_good_o(mpwr_good),
    .stable_o  (mpwr_stable)
  );

  // ============================================================
  // Sequence events
  assign supply_drop = !core_good || !mpwr_good; // [R07]
  assign por_go      = core_stable; // [R01]
  assign pulse_end   = (r.cnt == PULSE_LAST); // [R03]
  assign gap_end     = (r.cnt == GAP_LAST); // [R04]
  assign mgmt_go     = mclk_stable & mpwr_stable; // [R05] [R06]

  // ============================================================
  // Release sequence
  always_comb begin
    next_r = r;
    unique case (r.st)
      reset_seq_pkg::ST_HOLD: begin
        // Wait for the core supply to come up
        next_r.cnt    = '0;
        next_r.por_n  = 1'b0;
        next_r.sys_n  = 1'b0;
        next_r.chip_n = 1'b0;
        next_r.soft_n = 1'b0;
        if (core_good) begin
          next_r.st = reset_seq_pkg::ST_POR_WAIT;
        end
      end

      reset_seq_pkg::ST_POR_WAIT: begin
        // Power-on delay runs in the core filter
        next_r.chip_n = 1'b0;
        next_r.soft_n = 1'b0;
        if (por_go) begin
          next_r.por_n = 1'b1; // [R01]
          next_r.sys_n = 1'b1; // [R02]
          next_r.cnt   = '0;
          next_r.st    = reset_seq_pkg::ST_PULSE;
        end else begin
          next_r.cnt = '0;
        end
      end

      reset_seq_pkg::ST_PULSE: begin
        // Chip and soft clears still asserted
        next_r.chip_n = 1'b0;
        if (pulse_end) begin
          next_r.soft_n = 1'b1; // [R03] [R04]
          next_r.cnt    = '0;
          next_r.st     = reset_seq_pkg::ST_SOFT_GAP;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end

      reset_seq_pkg::ST_SOFT_GAP: begin
        // Soft clear released, chip clear held
        if (gap_end) begin
          next_r.chip_n = 1'b1; // [R04]
          next_r.st     = reset_seq_pkg::ST_RUN;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end

      reset_seq_pkg::ST_RUN: begin
        // All controller clears released
        next_r.cnt    = '0;
        next_r.por_n  = 1'b1;
        next_r.sys_n  = 1'b1;
        next_r.chip_n = 1'b1;
        next_r.soft_n = 1'b1;
      end
    endcase
    next_r.mgmt_n = mgmt_go; // [R05] [R06]
    if (supply_drop) begin
      next_r.st     = reset_seq_pkg::ST_HOLD; // [R07]
      next_r.cnt    = '0;
      next_r.por_n  = 1'b0;
      next_r.sys_n  = 1'b0;
      next_r.chip_n = 1'b0;
      next_r.soft_n = 1'b0;
      next_r.mgmt_n = 1'b0;
    end
    next_r.done = (next_r.st == reset_seq_pkg::ST_RUN);
  end

  // ============================================================
  // State register
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= SEQ_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ============================================================
  // Controller chip clears
  assign system_poweron_clear_n_o = r.por_n;
  assign system_clear_n_o         = r.sys_n;
  assign chip_clear_n_o           = r.chip_n;
  assign soft_clear_n_o           = r.soft_n;

  // ============================================================
  // Management clear and status
  assign mgmt_ctrl_clear_n_o      = r.mgmt_n;
  assign seq_done_o               = r.done;
endmodule : board_reset_sequencer

// >>> verilog/reset_seq_pkg.sv
// Package with timing constants and state encodings for the reset sequencer
// ============================================================
// Summary of operation
// R01 - Hold the supervisor power-on clear until the core supply has been good for at least 1 ms, then release it.
// R02 - Release the system clear no earlier than the power-on clear, with zero separation allowed.
// R03 - Every asserted pulse of the chip clear or soft clear lasts at least 5 us.
// R04 - Release the soft clear first and keep the chip clear asserted at least 5 us longer.
// R05 - Hold the management controller clear until its reference clock has been stable for at least 500 us.
// R06 - Hold the management controller clear until all its supplies have been stable for at least 1 ms.
// R07 - If any monitored supply-good input drops, reassert all clears at once and restart the whole sequence.
// ============================================================
package reset_seq_pkg;
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned POR_DELAY_US   = 1000;
  localparam int unsigned PULSE_US       = 5;
  localparam int unsigned SOFT_GAP_US    = 5;
  localparam int unsigned MCLK_STABLE_US = 500;
  localparam int unsigned MPWR_STABLE_US = 1000;
  localparam int unsigned CYC_PER_US     = CLK_HZ / 1_000_000;
  localparam int unsigned POR_CYC        = POR_DELAY_US * CYC_PER_US;
  localparam int unsigned PULSE_CYC      = PULSE_US * CYC_PER_US;
  localparam int unsigned SOFT_GAP_CYC   = SOFT_GAP_US * CYC_PER_US;
  localparam int unsigned MCLK_CYC       = MCLK_STABLE_US * CYC_PER_US;
  localparam int unsigned MPWR_CYC       = MPWR_STABLE_US * CYC_PER_US;
  localparam int unsigned CNT_W          = 24;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_POR_WAIT,
    ST_PULSE,
    ST_SOFT_GAP,
    ST_RUN
  } seq_state_e;
endpackage : reset_seq_pkg

// >>> verilog/stable_timer.sv
// Synchroniser and stability timer for one group of status inputs
`timescale 1ns/1ps
module stable_timer #(
  parameter int unsigned WIDTH    = 1,
  parameter int unsigned HOLD_CYC = 20000,
  parameter int unsigned CNT_W    = 24
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  // Status inputs from outside
  input  wire logic [WIDTH-1:0] level_i,
  // Filtered status
  output logic                  all_good_o,
  output logic                  stable_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] filt;
    logic [CNT_W-1:0] cnt;
    logic             done;
  } st_s;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(HOLD_CYC - 1);

  st_s r;
  st_s next_r;

  // ============================================================
  // Filter and count
  always_comb begin
    next_r    = r;
    next_r.s1 = level_i;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.filt[i] = r.s3[i];
      end
    end
    if (!(&r.filt)) begin
      next_r.cnt  = '0;
      next_r.done = 1'b0;
    end else if (!r.done) begin
      if (r.cnt == LAST) begin
        next_r.done = 1'b1;
      end else begin
        next_r.cnt = r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign all_good_o = &r.filt;
  assign stable_o   = r.done & (&r.filt);
endmodule : stable_timer
